// [verilog/psc_cfg.svh]
// Constants of the power and state control block
`ifndef PSC_CFG_SVH
`define PSC_CFG_SVH

// Deglitch lengths in clock samples
`define PSC_FILT_LEN      4
`define PSC_POR_FILT_LEN  2

// Bit positions inside the deglitched input vector
`define PSC_NUM_FILT      5
`define PSC_IDX_PWRFAIL   0
`define PSC_IDX_BATTOK    1
`define PSC_IDX_NEWBAT    2
`define PSC_IDX_WAKE      3
`define PSC_IDX_URESET    4

// Reset values of the deglitched levels (inactive levels)
`define PSC_FILT_INIT     5'h17

// Test mode selection held when nothing was captured
`define PSC_TEST_RST      3'h7

`endif

// [verilog/psc_pkg.sv]
// Types of the power and state control block
package psc_pkg;

    typedef enum logic [1:0] {
        PSC_OPERATING = 2'h0,
        PSC_IDLE      = 2'h1,
        PSC_STANDBY   = 2'h2
    } psc_state_t;

    // Supervision pins, all asynchronous to clk
    typedef struct packed {
        logic user_reset_n;
        logic wake_request;
        logic new_battery_sense_n;
        logic battery_good;
        logic power_fail_n;
    } psc_supv_t;

    // Status levels seen by the rest of the chip
    typedef struct packed {
        logic por_done;
        logic new_battery_low;
        logic external_supply;
    } psc_status_t;

endpackage : psc_pkg

// [verilog/psc_deglitch.sv]
// Two-stage synchroniser followed by a stable-level filter
module psc_deglitch #(
    parameter int LEN  = 4,
    parameter bit INIT = 1'b1
) (
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic pin,
    output logic      level
);

    localparam int CW = $clog2(LEN + 1);
    localparam logic [CW-1:0] LAST = CW'(LEN - 1);

    generate
        if (LEN < 1) begin : g_bad_len
            $error("psc_deglitch: LEN must be at least 1");
        end
    endgenerate

    logic          sync1_r;
    logic          sync2_r;
    logic          lvl_r;
    logic          lvl_nxt;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;

    ////////////////////////////////////////////////////////////////////////
    // New level only after LEN equal samples in a row
    always_comb begin
        lvl_nxt = lvl_r;
        cnt_nxt = '0;
        if (sync2_r != lvl_r) begin
            if (cnt_r == LAST) begin
                lvl_nxt = sync2_r; // RULE15
            end else begin
                cnt_nxt = cnt_r + CW'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            sync1_r <= INIT;
            sync2_r <= INIT;
            lvl_r   <= INIT;
            cnt_r   <= '0;
        end else begin
            sync1_r <= pin;
            sync2_r <= sync1_r;
            lvl_r   <= lvl_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    assign level = lvl_r;

    ////////////////////////////////////////////////////////////////////////
    chk_filter_stable: assert property ( // RULE15
        @(posedge clk) disable iff (srst)
        (lvl_r != $past(lvl_r)) |-> ($past(cnt_r) == LAST)
    ) else $error("deglitch output changed before filter length");

endmodule : psc_deglitch

// [verilog/psc_top.sv]
// Power management and system state control
// Function
// (RULE1) Deglitched power fail low forces the system into Standby.
// (RULE2) Falling edge of deglitched battery good raises a fast interrupt.
// (RULE3) Low battery good in Standby blocks every exit from Standby.
// (RULE4) Board holds external supply sense low when externally powered.
// (RULE5) New battery sense input is deglitched.
// (RULE6) Power-on reset low resets all state control logic.
// (RULE7) Power-on reset is held low at least two clock cycles.
// (RULE8) Pin select chooses run status or clock gate on state pin.
// (RULE9) Run status: pin high in Operating or Idle, low in Standby.
// (RULE10) Clock gate: pin low only in Standby, high otherwise.
// (RULE11) Wake rising edge enters Operating, only after power-on reset.
// (RULE12) User reset is an active low deglitched reset request.
// (RULE13) Power-on reset release captures user reset and two test straps.
// (RULE14) In Standby buses are forced low and peripherals held in reset.
// (RULE15) Deglitched inputs change only after several stable samples.
// (RULE16) A Standby cause beats a simultaneous wake event.
`include "psc_cfg.svh"

module psc_top
    import psc_pkg::*;
#(
    parameter int FILT_LEN     = `PSC_FILT_LEN,
    parameter int POR_FILT_LEN = `PSC_POR_FILT_LEN
) (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire psc_supv_t   supv_pins,
    input  wire logic        power_on_reset_n,
    input  wire logic        external_supply_sense_n,
    input  wire logic [1:0]  test_mode_straps,
    input  wire logic        state_pin_select,
    input  wire logic        idle_request,
    input  wire logic        idle_exit,
    input  wire logic        standby_request,
    output logic             state_output_pin,
    output logic             fast_interrupt,
    output psc_state_t       system_state,
    output logic             bus_force_low,
    output logic             periph_reset,
    output logic             user_reset_req,
    output logic [2:0]       test_mode_sel,
    output psc_status_t      status
);

    generate
        if (FILT_LEN < 2 || POR_FILT_LEN < 2) begin : g_bad_par
            $error("psc_top: filter lengths must be at least 2");
        end
    endgenerate

    function automatic logic psc_in_standby(input psc_state_t s);
        return (s == PSC_STANDBY);
    endfunction : psc_in_standby

    ////////////////////////////////////////////////////////////////////////
    // Input conditioning
    logic [`PSC_NUM_FILT-1:0] raw_pins;
    logic [`PSC_NUM_FILT-1:0] filt;
    logic                     por_f;

    assign raw_pins = supv_pins;

    genvar gi;
    generate
        for (gi = 0; gi < `PSC_NUM_FILT; gi++) begin : g_filt
            psc_deglitch #(
                .LEN  (FILT_LEN),
                .INIT (1'(`PSC_FILT_INIT >> gi))
            ) u_filt (
                .clk   (clk),
                .srst  (srst),
                .pin   (raw_pins[gi]), // RULE5 RULE12
                .level (filt[gi])
            );
        end
    endgenerate

    // Two samples suffice: the reset source guarantees that width
    psc_deglitch #(
        .LEN  (POR_FILT_LEN),
        .INIT (1'b0)
    ) u_por (
        .clk   (clk),
        .srst  (srst),
        .pin   (power_on_reset_n), // RULE7
        .level (por_f)
    );

    logic       pwrfail_f;
    logic       battok_f;
    logic       newbat_f;
    logic       wake_f;
    logic       ureset_f;
    logic       sys_rst;

    assign pwrfail_f = filt[`PSC_IDX_PWRFAIL];
    assign battok_f  = filt[`PSC_IDX_BATTOK];
    assign newbat_f  = filt[`PSC_IDX_NEWBAT];
    assign wake_f    = filt[`PSC_IDX_WAKE];
    assign ureset_f  = filt[`PSC_IDX_URESET];
    assign sys_rst   = srst | ~por_f; // RULE6

    // Plain synchronisers for undeglitched pins
    logic [2:0] strap_s1_r;
    logic [2:0] strap_s2_r;
    logic [2:0] strap_s1_nxt;
    logic       ext_s1_r;
    logic       ext_s2_r;
    logic       ext_s1_nxt;

    always_comb begin
        strap_s1_nxt = {supv_pins.user_reset_n, test_mode_straps};
        ext_s1_nxt   = external_supply_sense_n; // RULE4
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            strap_s1_r <= 3'h7;
            strap_s2_r <= 3'h7;
            ext_s1_r   <= 1'h1;
            ext_s2_r   <= 1'h1;
        end else begin
            strap_s1_r <= strap_s1_nxt;
            strap_s2_r <= strap_s1_r;
            ext_s1_r   <= ext_s1_nxt;
            ext_s2_r   <= ext_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Test strap capture on release of power-on reset
    logic       por_q_r;
    logic       por_q_nxt;
    logic       por_rise;
    logic [2:0] test_r;
    logic [2:0] test_nxt;

    assign por_rise = por_f & ~por_q_r;

    always_comb begin
        por_q_nxt = por_f;
        test_nxt  = test_r;
        if (por_rise) begin
            test_nxt = strap_s2_r; // RULE13
        end
    end

    // Only srst clears the straps, so they survive until the next release
    always_ff @(posedge clk) begin
        if (srst) begin
            por_q_r <= 1'h0;
            test_r  <= `PSC_TEST_RST;
        end else begin
            por_q_r <= por_q_nxt;
            test_r  <= test_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Edge detection and system state
    psc_state_t state_r;
    psc_state_t state_nxt;
    logic       wake_prev_r;
    logic       battok_prev_r;
    logic       por_done_r;
    logic       wake_rise;
    logic       batt_fall;
    logic       standby_cause;

    // Previous values start at levels that fake no edge after reset
    assign wake_rise     = wake_f & ~wake_prev_r;
    assign batt_fall     = battok_prev_r & ~battok_f;
    assign standby_cause = ~pwrfail_f | ~ureset_f | standby_request;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            PSC_STANDBY: begin
                if (!standby_cause && battok_f && wake_rise
                    && por_done_r) begin // RULE3 RULE11 RULE16
                    state_nxt = PSC_OPERATING;
                end
            end
            PSC_OPERATING: begin
                if (standby_cause) begin
                    state_nxt = PSC_STANDBY; // RULE1 RULE12
                end else if (idle_request) begin
                    state_nxt = PSC_IDLE;
                end
            end
            PSC_IDLE: begin
                if (standby_cause) begin
                    state_nxt = PSC_STANDBY; // RULE1 RULE16
                end else if (idle_exit || wake_rise) begin
                    state_nxt = PSC_OPERATING; // RULE11
                end
            end
            default: begin
                state_nxt = PSC_STANDBY;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs; pin, bus and peripheral reset are computed from the next state so they track it
    logic        pin_nxt;
    logic        run_sig;
    logic        gate_sig;
    psc_status_t status_nxt;

    always_comb begin
        run_sig  = ~psc_in_standby(state_nxt); // RULE9
        gate_sig = ~psc_in_standby(state_nxt); // RULE10
        pin_nxt  = state_pin_select ? gate_sig : run_sig; // RULE8
        status_nxt.por_done        = 1'h1;
        status_nxt.new_battery_low = ~newbat_f;
        status_nxt.external_supply = ~ext_s2_r;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_r          <= PSC_STANDBY; // RULE6
            wake_prev_r      <= 1'h1;
            battok_prev_r    <= 1'h0;
            por_done_r       <= 1'h0;
            state_output_pin <= 1'h0;
            fast_interrupt   <= 1'h0;
            bus_force_low    <= 1'h1;
            periph_reset     <= 1'h1;
            user_reset_req   <= 1'h0;
            status           <= '0;
        end else begin
            state_r          <= state_nxt;
            wake_prev_r      <= wake_f;
            battok_prev_r    <= battok_f;
            por_done_r       <= 1'h1;
            state_output_pin <= pin_nxt;
            fast_interrupt   <= batt_fall; // RULE2
            bus_force_low    <= psc_in_standby(state_nxt); // RULE14
            periph_reset     <= psc_in_standby(state_nxt); // RULE14
            user_reset_req   <= ~ureset_f; // RULE12
            status           <= status_nxt;
        end
    end

    assign system_state  = state_r;
    assign test_mode_sel = test_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    chk_pwrfail_standby: assert property ( // RULE1
        !pwrfail_f |=> system_state == PSC_STANDBY
    ) else $error("power fail did not force standby");

    chk_batt_fiq: assert property ( // RULE2
        battok_prev_r && !battok_f |=> fast_interrupt ##1 !fast_interrupt
    ) else $error("battery fall did not pulse fast interrupt");

    chk_batt_blocks: assert property ( // RULE3
        system_state == PSC_STANDBY && !battok_f
        |=> system_state == PSC_STANDBY
    ) else $error("left standby with battery not good");

    chk_por_reset: assert property ( // RULE6
        @(posedge clk) disable iff (srst)
        !por_f |=> system_state == PSC_STANDBY && !fast_interrupt
            && periph_reset
    ) else $error("power-on reset did not reset state");

    chk_pin_mux: assert property ( // RULE9 RULE10
        state_output_pin == !psc_in_standby(system_state)
    ) else $error("state pin disagrees with state");

    chk_wake_enter: assert property ( // RULE11
        system_state == PSC_STANDBY && wake_rise && battok_f
        && !standby_cause && por_done_r |=> system_state == PSC_OPERATING
    ) else $error("wake edge did not enter operating");

    chk_strap_latch: assert property ( // RULE13
        @(posedge clk) disable iff (srst)
        por_rise |=> test_mode_sel == $past(strap_s2_r)
    ) else $error("straps not captured at reset release");

    chk_bus_low: assert property ( // RULE14
        bus_force_low == psc_in_standby(system_state)
        && periph_reset == bus_force_low
    ) else $error("bus force low wrong for state");

    chk_standby_wins: assert property ( // RULE16
        standby_cause |=> system_state == PSC_STANDBY
    ) else $error("wake beat a standby cause");

    cov_wake: cover property (
        system_state == PSC_STANDBY ##1 system_state == PSC_OPERATING);
    cov_idle: cover property (
        system_state == PSC_OPERATING ##1 system_state == PSC_IDLE);
    cov_fiq: cover property (fast_interrupt);
    cov_pwrfail: cover property (
        system_state == PSC_IDLE && !pwrfail_f
        ##1 system_state == PSC_STANDBY);

endmodule : psc_top

// [dv/psc_board_model.sv]
// Board supervisor, battery sensors and reset button model
module psc_board_model
    import psc_pkg::*;
(
    input  wire logic  clk,
    output psc_supv_t  supv_pins,
    output logic       power_on_reset_n,
    output logic       external_supply_sense_n,
    output logic [1:0] test_mode_straps
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        supv_pins               = 5'h17;
        power_on_reset_n        = 1'b1;
        external_supply_sense_n = 1'b1;
        test_mode_straps        = 2'h3;
    end

    ////////////////////////////////////////////////////////////////////
    // Pins change only at the falling edge, far from the sampling edge
    task automatic drive(input psc_supv_t v);
        @(negedge clk);
        supv_pins = v;
    endtask : drive

    // Low level marks an external supply
    task automatic set_ext(input logic on);
        @(negedge clk);
        external_supply_sense_n = ~on;
    endtask : set_ext

    // Short dip on power fail, below the filter length
    task automatic glitch(input int n);
        @(negedge clk);
        supv_pins.power_fail_n = 1'b0;
        repeat (n) @(negedge clk);
        supv_pins.power_fail_n = 1'b1;
    endtask : glitch

    // Straps and reset button settle before release and stay after it
    task automatic por_pulse(input int n, input logic [2:0] v);
        @(negedge clk);
        supv_pins.user_reset_n = v[2];
        test_mode_straps       = v[1:0];
        power_on_reset_n       = 1'b0;
        repeat ((n < 4) ? 4 : n) @(negedge clk);
        power_on_reset_n = 1'b1;
    endtask : por_pulse
endmodule : psc_board_model

// [dv/power_state_control_tb.sv]
// Self-checking testbench of the power and state control block
module power_state_control_tb
    import psc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk = 1'b0;
    logic        srst = 1'b1;
    psc_supv_t   supv;
    logic        por_n;
    logic        ext_n;
    logic [1:0]  straps;
    logic        sel = 1'b0;
    logic        idle_req = 1'b0;
    logic        idle_ex = 1'b0;
    logic        sby_req = 1'b0;
    logic        state_output_pin;
    logic        fast_interrupt;
    psc_state_t  system_state;
    logic        bus_force_low;
    logic        periph_reset;
    logic        user_reset_req;
    logic [2:0]  test_mode_sel;
    psc_status_t status;
    int          err_count = 0;
    int          tests_run = 0;
    int          cyc = 0;
    int          fiq_cnt = 0;
    int          f0;
    logic [2:0]  r;

    always #20 clk = ~clk;

    psc_board_model u_board (
        .clk(clk), .supv_pins(supv), .power_on_reset_n(por_n),
        .external_supply_sense_n(ext_n), .test_mode_straps(straps)
    );

    psc_top u_dut (
        .clk(clk), .srst(srst), .supv_pins(supv),
        .power_on_reset_n(por_n), .external_supply_sense_n(ext_n),
        .test_mode_straps(straps), .state_pin_select(sel),
        .idle_request(idle_req), .idle_exit(idle_ex),
        .standby_request(sby_req), .state_output_pin(state_output_pin),
        .fast_interrupt(fast_interrupt), .system_state(system_state),
        .bus_force_low(bus_force_low), .periph_reset(periph_reset),
        .user_reset_req(user_reset_req), .test_mode_sel(test_mode_sel),
        .status(status)
    );

    ////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop

    // Hang guard, generous against the roughly 450 cycles needed
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (fast_interrupt === 1'b1) begin
            fiq_cnt <= fiq_cnt + 1;
        end
        if (cyc == 20000) begin
            err_count++;
            report_and_stop();
        end
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : check

    function automatic logic [7:0] st(input psc_state_t s);
        return 8'(s);
    endfunction : st

    // Pin level expected for a state, same for both selections
    function automatic logic [7:0] pin_exp(input psc_state_t s);
        return (s == PSC_STANDBY) ? 8'h00 : 8'h01;
    endfunction : pin_exp

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick

    // Pulse a same-clock request for one cycle
    task automatic pulse(ref logic s);
        @(negedge clk);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
        tick(2);
    endtask : pulse

    // Wake low then high with battery good set to batt, ending after the filter
    task automatic wake_edge(input logic batt);
        u_board.drive({1'b1, 1'b0, 1'b1, batt, 1'b1});
        tick(12);
        u_board.drive({1'b1, 1'b1, 1'b1, batt, 1'b1});
        tick(12);
    endtask : wake_edge

    ////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(949));
        tick(12);
        srst = 1'b0;
        tick(10);
        check(st(system_state), st(PSC_STANDBY));
        check(8'(bus_force_low), 8'h01);
        check(8'(periph_reset), 8'h01);
        check(8'(state_output_pin), 8'h00);
        check(8'(test_mode_sel), 8'h07);
        $display("test reset state done");

        wake_edge(1'b0);
        check(st(system_state), st(PSC_STANDBY));
        wake_edge(1'b1);
        check(st(system_state), st(PSC_OPERATING));
        for (int i = 0; i < 2; i++) begin
            sel = i[0];
            tick(2);
            check(8'(state_output_pin), pin_exp(PSC_OPERATING));
        end
        sel = 1'($urandom % 2);
        $display("test wake done");

        pulse(idle_req);
        check(st(system_state), st(PSC_IDLE));
        check(8'(state_output_pin), pin_exp(PSC_IDLE));
        pulse(idle_ex);
        check(st(system_state), st(PSC_OPERATING));
        $display("test idle done");

        u_board.glitch(2);
        tick(12);
        check(st(system_state), st(PSC_OPERATING));
        pulse(idle_req);
        check(st(system_state), st(PSC_IDLE));
        u_board.drive({1'b1, 1'b1, 1'b1, 1'b1, 1'b0});
        tick(12);
        check(st(system_state), st(PSC_STANDBY));
        check(8'(state_output_pin), pin_exp(PSC_STANDBY));
        check(8'(bus_force_low), 8'h01);
        $display("test power fail done");

        sby_req = 1'b1;
        wake_edge(1'b1);
        check(st(system_state), st(PSC_STANDBY));
        sby_req = 1'b0;
        wake_edge(1'b1);
        check(st(system_state), st(PSC_OPERATING));
        $display("test standby priority done");

        f0 = fiq_cnt;
        u_board.drive({1'b1, 1'b1, 1'b1, 1'b0, 1'b1});
        tick(12);
        check(8'(fiq_cnt - f0), 8'h01);
        u_board.drive({1'b1, 1'b0, 1'b0, 1'b1, 1'b1});
        u_board.set_ext(1'b1);
        tick(12);
        check(8'(status), 8'h07);
        u_board.drive({1'b0, 1'b0, 1'b1, 1'b1, 1'b1});
        u_board.set_ext(1'b0);
        tick(12);
        check(8'(user_reset_req), 8'h01);
        check(8'(status), 8'h04);
        $display("test supervision inputs done");

        for (int k = 0; k < 4; k++) begin
            wake_edge(1'b1);
            r = (k == 0) ? 3'h2 : 3'($urandom % 8);
            u_board.por_pulse(4 + int'($urandom % 4), r);
            tick(12);
            check(8'(test_mode_sel), 8'(r));
            check(st(system_state), st(PSC_STANDBY));
            u_board.drive({1'b1, 1'b0, 1'b1, 1'b1, 1'b1});
            tick(12);
        end
        $display("test power on reset done");
        report_and_stop();
    end
endmodule : power_state_control_tb
